// ==== smbus_charger_pkg.sv ====
// Constants shared by the charger slave port
package smbus_charger_pkg;

  // ----------------------------------------------------------------------
  // Bus addresses and register commands
  // ----------------------------------------------------------------------
  localparam logic [7:0] HOST_WRITE_ADDRESS = 8'h12;
  localparam logic [7:0] HOST_READ_ADDRESS  = 8'h13;
  localparam logic [7:0] CMD_CHARGER_MODE   = 8'h12;
  localparam logic [7:0] CMD_CHARGER_STATUS = 8'h13;
  localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_INPUT_CURRENT  = 8'h3f;

  // ----------------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------------
  localparam int          REG_W             = 16;
  localparam int          BYTE_W            = 8;
  localparam int          STATUS_CHGOC_BIT  = 0;
  localparam int          STATUS_ACOC_BIT   = 1;
  localparam logic [15:0] MODE_RESET        = 16'h0000;
  localparam logic [15:0] CURRENT_RESET     = 16'h0000;
  localparam logic [15:0] VOLTAGE_RESET     = 16'h0000;
  localparam logic [15:0] INPUT_CUR_RESET   = 16'h0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint CORE_CLK_HZ       = 200000000;
  localparam longint ALERT_DELAY_MS    = 6;
  localparam longint BUS_RELEASE_MS    = 25;
  localparam longint WDOG_DEGLITCH_MS  = 10;
  localparam longint WDOG_TIMEOUT_S    = 140;
  localparam int     TIMER_W           = 36;
  localparam logic [35:0] ALERT_DELAY_CYC =
    36'(ALERT_DELAY_MS * CORE_CLK_HZ / 1000);
  localparam logic [35:0] BUS_RELEASE_CYC =
    36'(BUS_RELEASE_MS * CORE_CLK_HZ / 1000);
  localparam logic [35:0] WDOG_DEGLITCH_CYC =
    36'(WDOG_DEGLITCH_MS * CORE_CLK_HZ / 1000);
  localparam logic [35:0] WDOG_TIMEOUT_CYC =
    36'(WDOG_TIMEOUT_S * CORE_CLK_HZ);

endpackage

// ==== sync_bits.sv ====
// Two-stage synchroniser for a group of independent levels
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  if (W < 1) begin : g_bad_w
    $error("sync_bits: W must be at least 1");
  end

  always_ff @(posedge i_clk) begin
    meta_ff <= i_async;
    sync_ff <= meta_ff;
  end

  assign o_sync = sync_ff;
endmodule

// ==== delay_timer.sv ====
// Saturating timer: done once run has held for LIMIT+1 cycles
`timescale 1ns/1ps
module delay_timer #(
  parameter int               CNT_W = 36,
  parameter logic [CNT_W-1:0] LIMIT = 1
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_done
);
  logic [CNT_W-1:0] count_ff;
  logic             done_ff;

  if (LIMIT == '0) begin : g_bad_limit
    $error("delay_timer: LIMIT must be at least 1");
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      count_ff <= '0;
    end else if (count_ff != LIMIT) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= i_run && (count_ff == LIMIT);
    end
  end

  assign o_done = done_ff;
endmodule

// ==== smbus_charger_slave_port.sv ====
// Word-oriented bus slave port of the charger controller
//
// Functional notes
// RQ1 - Slave only; host writes and reads internal registers over clock/data.
// RQ2 - Acknowledge address 0x12 as write and 0x13 as read; code acknowledges 0x13 only while a valid command is stored.
// RQ3 - Any other address, global ones included, is not acknowledged.
// RQ4 - No checksum byte; none generated or checked.
// RQ5 - Host clocks the bus between 10 and 100 kHz.
// RQ6 - Byte after write address selects the register to access.
// RQ7 - Decode commands 0x12, 0x13 (read-only), 0x14, 0x15 and 0x3f.
// RQ8 - All transfers are 8-bit bytes in both directions.
// RQ9 - Device never creates START or STOP itself in normal operation.
// RQ10 - Release data line after it is held low past the timeout.
// RQ11 - Alert rises 6 to 10 ms after a status bit changes.
// RQ12 - Host-communication watchdog expires after 140 s unserviced.
// RQ13 - Watchdog reset input must hold about 10 ms before acting.
// RQ14 - Data line only pulled low or released, never driven high.
// RQ15 - Host clears latched faults by reading the status register.
// RQ16 - Word write commits only at end of second data acknowledge.
// RQ17 - Unsupported command is not acknowledged and not stored.
// RQ18 - Read after repeated start returns two bytes of selected register.
// RQ19 - START or STOP aborts; STOP returns to idle until next START.
// RQ20 - Bus lines synchronised; START/STOP are data edges with clock high.
// RQ21 - Registers are 16 bits, low byte first on the bus.
`timescale 1ns/1ps
module smbus_charger_slave_port #(
  parameter logic [35:0] ALERT_CYC    = smbus_charger_pkg::ALERT_DELAY_CYC,
  parameter logic [35:0] RELEASE_CYC  = smbus_charger_pkg::BUS_RELEASE_CYC,
  parameter logic [35:0] DEGLITCH_CYC = smbus_charger_pkg::WDOG_DEGLITCH_CYC,
  parameter logic [35:0] WDOG_CYC     = smbus_charger_pkg::WDOG_TIMEOUT_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda_in,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic [15:0] i_status_flags,
  input  wire logic        i_chgoc_detect,
  input  wire logic        i_acoc_detect,
  input  wire logic        i_watchdog_reset,
  output logic             o_alert,
  output logic             o_watchdog_expired,
  output logic [15:0]      o_charger_mode,
  output logic [15:0]      o_charge_current,
  output logic [15:0]      o_charge_voltage,
  output logic [15:0]      o_input_current
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } port_state_t;

  // ----------------------------------------------------------------------
  // Link clock domain: capture data on each rising bus clock
  // ----------------------------------------------------------------------
  logic link_tgl_ff = 1'b0;
  logic link_bit_ff = 1'b1;

  always_ff @(posedge i_scl) begin // see RQ8
    link_tgl_ff <= ~link_tgl_ff;
    link_bit_ff <= i_sda_in;
  end

  // ----------------------------------------------------------------------
  // Synchronisers and bus events
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 22;
  logic [SYNC_W-1:0] sync_out;
  logic        tgl_s, scl_s, sda_s, wdi_s, chgoc_s, acoc_s;
  logic [15:0] status_s;
  logic        tgl_d_ff, scl_d_ff, sda_d_ff;
  logic        start_ev, stop_ev, rise_ev, fall_ev, abort_ev;

  sync_bits #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk   (i_core_clk),
    .i_async ({link_tgl_ff, i_scl, i_sda_in, i_watchdog_reset,
               i_chgoc_detect, i_acoc_detect, i_status_flags}),
    .o_sync  (sync_out)
  );

  assign {tgl_s, scl_s, sda_s, wdi_s, chgoc_s, acoc_s, status_s} = sync_out;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tgl_d_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      tgl_d_ff <= tgl_s;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign start_ev = scl_s && scl_d_ff && sda_d_ff && !sda_s; // see RQ20
  assign stop_ev  = scl_s && scl_d_ff && !sda_d_ff && sda_s; // see RQ20
  assign rise_ev  = (tgl_s != tgl_d_ff) && !i_sys_rst;
  assign fall_ev  = scl_d_ff && !scl_s && !i_sys_rst;

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  logic release_done, alert_done, deglitch_done, wdog_done;
  logic alert_pend_ff, wdog_svc, deg_d_ff;

  delay_timer #(
    .CNT_W (smbus_charger_pkg::TIMER_W),
    .LIMIT (RELEASE_CYC)
  ) u_release (
    .i_clk  (i_core_clk),
    .i_rst  (i_sys_rst),
    .i_run  (!sda_s),
    .o_done (release_done)
  );

  delay_timer #(
    .CNT_W (smbus_charger_pkg::TIMER_W),
    .LIMIT (ALERT_CYC)
  ) u_alert (
    .i_clk  (i_core_clk),
    .i_rst  (i_sys_rst),
    .i_run  (alert_pend_ff),
    .o_done (alert_done)
  );

  delay_timer #(
    .CNT_W (smbus_charger_pkg::TIMER_W),
    .LIMIT (DEGLITCH_CYC)
  ) u_deglitch (
    .i_clk  (i_core_clk),
    .i_rst  (i_sys_rst),
    .i_run  (wdi_s),
    .o_done (deglitch_done)
  );

  delay_timer #(
    .CNT_W (smbus_charger_pkg::TIMER_W),
    .LIMIT (WDOG_CYC)
  ) u_wdog (
    .i_clk  (i_core_clk),
    .i_rst  (i_sys_rst),
    .i_run  (!wdog_svc),
    .o_done (wdog_done)
  );

  assign abort_ev = start_ev || stop_ev || release_done;

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  port_state_t state_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  tx_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rd_word;
  logic [7:0]  cmd_ff;
  logic        cmd_valid_ff, byte_idx_ff, oe_ff, sda_out_ff;
  logic        byte_end, cmd_ok, cmd_take, cmd_drop, wr_commit, rd_done;

  function automatic logic is_valid_cmd(input logic [7:0] c);
    return c == smbus_charger_pkg::CMD_CHARGER_MODE   ||
           c == smbus_charger_pkg::CMD_CHARGER_STATUS ||
           c == smbus_charger_pkg::CMD_CHARGE_CURRENT ||
           c == smbus_charger_pkg::CMD_CHARGE_VOLTAGE ||
           c == smbus_charger_pkg::CMD_INPUT_CURRENT;
  endfunction

  assign byte_end  = fall_ev && !abort_ev && (bit_cnt_ff == 4'h8);
  assign cmd_ok    = is_valid_cmd(shift_ff); // see RQ7
  assign cmd_take  = byte_end && state_ff == ST_CMD && cmd_ok;
  assign cmd_drop  = byte_end && state_ff == ST_CMD && !cmd_ok;
  assign wr_commit = fall_ev && !abort_ev && state_ff == ST_WACK &&
                     byte_idx_ff; // see RQ16
  assign rd_done   = fall_ev && !abort_ev && state_ff == ST_RACK &&
                     byte_idx_ff;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      tx_ff       <= 8'h00;
      wdata_ff    <= 16'h0000;
      byte_idx_ff <= 1'b0;
      oe_ff       <= 1'b0;
    end else if (stop_ev || release_done) begin // see RQ10
      state_ff <= ST_IDLE; // see RQ19
      oe_ff    <= 1'b0;
    end else if (start_ev) begin // see RQ19
      state_ff   <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      oe_ff      <= 1'b0;
    end else if (rise_ev && state_ff != ST_IDLE) begin
      shift_ff   <= {shift_ff[6:0], link_bit_ff}; // see RQ8
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (fall_ev) begin // see RQ9
      case (state_ff)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            oe_ff      <= 1'b1;
            if (state_ff == ST_ADDR) begin
              if (shift_ff == smbus_charger_pkg::HOST_WRITE_ADDRESS ||
                  (shift_ff == smbus_charger_pkg::HOST_READ_ADDRESS &&
                   cmd_valid_ff)) begin // see RQ2
                state_ff <= ST_AACK;
              end else begin
                state_ff <= ST_IDLE; // see RQ3
                oe_ff    <= 1'b0;
              end
            end else if (state_ff == ST_CMD) begin
              state_ff <= cmd_ok ? ST_CACK : ST_IDLE; // see RQ17
              oe_ff    <= cmd_ok;
            end else begin
              state_ff <= ST_WACK;
              if (byte_idx_ff) begin
                wdata_ff[15:8] <= shift_ff; // see RQ21
              end else begin
                wdata_ff[7:0] <= shift_ff;
              end
            end
          end
        end
        ST_AACK: begin
          bit_cnt_ff  <= 4'h0;
          byte_idx_ff <= 1'b0;
          // Ack bit already shifted in, so direction bit sits one place up
          if (shift_ff[1]) begin // see RQ18
            state_ff <= ST_RDATA;
            tx_ff    <= rd_word[7:0];
            oe_ff    <= ~rd_word[7];
          end else begin
            state_ff <= ST_CMD;
            oe_ff    <= 1'b0;
          end
        end
        ST_CACK: begin // see RQ6
          state_ff    <= ST_WDATA;
          bit_cnt_ff  <= 4'h0;
          byte_idx_ff <= 1'b0;
          oe_ff       <= 1'b0;
        end
        ST_WACK: begin
          oe_ff       <= 1'b0;
          bit_cnt_ff  <= 4'h0;
          byte_idx_ff <= 1'b1;
          state_ff    <= byte_idx_ff ? ST_IDLE : ST_WDATA; // see RQ4
        end
        ST_RDATA: begin
          if (bit_cnt_ff == 4'h8) begin
            state_ff   <= ST_RACK;
            bit_cnt_ff <= 4'h0;
            oe_ff      <= 1'b0;
          end else begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            oe_ff <= ~tx_ff[6]; // see RQ14
          end
        end
        ST_RACK: begin
          bit_cnt_ff <= 4'h0;
          if (!byte_idx_ff && !shift_ff[0]) begin // see RQ18
            state_ff    <= ST_RDATA;
            byte_idx_ff <= 1'b1;
            tx_ff       <= rd_word[15:8];
            oe_ff       <= ~rd_word[15];
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Stored command survives a repeated start, not a STOP
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || stop_ev || release_done || cmd_drop) begin
      cmd_valid_ff <= 1'b0; // see RQ17
      cmd_ff       <= cmd_ff;
    end else if (cmd_take) begin
      cmd_valid_ff <= 1'b1;
      cmd_ff       <= shift_ff;
    end
  end

  // Pull-down only; the pin's output level never changes
  always_ff @(posedge i_core_clk) begin
    sda_out_ff <= 1'b0; // see RQ14
  end

  // ----------------------------------------------------------------------
  // Registers, fault latches and status
  // ----------------------------------------------------------------------
  logic [15:0] mode_ff, ccur_ff, cvolt_ff, icur_ff, status_word, status_d_ff;
  logic        chgoc_lat_ff, acoc_lat_ff, status_rd, alert_ff, wdog_exp_ff;

  assign status_rd = rd_done && cmd_ff == smbus_charger_pkg::CMD_CHARGER_STATUS;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mode_ff  <= smbus_charger_pkg::MODE_RESET;
      ccur_ff  <= smbus_charger_pkg::CURRENT_RESET;
      cvolt_ff <= smbus_charger_pkg::VOLTAGE_RESET;
      icur_ff  <= smbus_charger_pkg::INPUT_CUR_RESET;
    end else if (wr_commit) begin // see RQ16
      case (cmd_ff)
        smbus_charger_pkg::CMD_CHARGER_MODE:   mode_ff  <= wdata_ff;
        smbus_charger_pkg::CMD_CHARGE_CURRENT: ccur_ff  <= wdata_ff;
        smbus_charger_pkg::CMD_CHARGE_VOLTAGE: cvolt_ff <= wdata_ff;
        smbus_charger_pkg::CMD_INPUT_CURRENT:  icur_ff  <= wdata_ff;
        default: mode_ff <= mode_ff;
      endcase
    end
  end

  // A new fault wins over a clearing read in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chgoc_lat_ff <= 1'b0;
      acoc_lat_ff  <= 1'b0;
    end else begin
      chgoc_lat_ff <= chgoc_s || (chgoc_lat_ff && !status_rd); // see RQ15
      acoc_lat_ff  <= acoc_s || (acoc_lat_ff && !status_rd); // see RQ15
    end
  end

  always_comb begin
    status_word = status_s;
    status_word[smbus_charger_pkg::STATUS_CHGOC_BIT] = chgoc_lat_ff;
    status_word[smbus_charger_pkg::STATUS_ACOC_BIT]  = acoc_lat_ff;
  end

  always_comb begin
    case (cmd_ff)
      smbus_charger_pkg::CMD_CHARGER_MODE:   rd_word = mode_ff;
      smbus_charger_pkg::CMD_CHARGER_STATUS: rd_word = status_word;
      smbus_charger_pkg::CMD_CHARGE_CURRENT: rd_word = ccur_ff;
      smbus_charger_pkg::CMD_CHARGE_VOLTAGE: rd_word = cvolt_ff;
      default:                               rd_word = icur_ff;
    endcase
  end

  // Alert raised once the change has aged; reading status drops it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      status_d_ff   <= 16'h0000;
      alert_pend_ff <= 1'b0;
      alert_ff      <= 1'b0;
    end else begin
      status_d_ff   <= status_word;
      alert_pend_ff <= (status_word != status_d_ff) ||
                       (alert_pend_ff && !alert_done); // see RQ11
      alert_ff      <= alert_done || (alert_ff && !status_rd); // see RQ11
    end
  end

  // Watchdog kicked by a committed write or a deglitched reset input
  assign wdog_svc = wr_commit || (deglitch_done && !deg_d_ff); // see RQ13

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      deg_d_ff    <= 1'b0;
      wdog_exp_ff <= 1'b0;
    end else begin
      deg_d_ff    <= deglitch_done;
      wdog_exp_ff <= wdog_done; // see RQ12
    end
  end

  assign o_sda_out          = sda_out_ff;
  assign o_sda_oe           = oe_ff; // see RQ1
  assign o_alert            = alert_ff;
  assign o_watchdog_expired = wdog_exp_ff;
  assign o_charger_mode     = mode_ff;
  assign o_charge_current   = ccur_ff;
  assign o_charge_voltage   = cvolt_ff;
  assign o_input_current    = icur_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_addr_ack;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (byte_end && state_ff == ST_ADDR &&
     shift_ff == smbus_charger_pkg::HOST_WRITE_ADDRESS) |=> o_sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) // see RQ2
    else $error("write address not acknowledged");

  property p_foreign_nack;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (byte_end && state_ff == ST_ADDR &&
     shift_ff != smbus_charger_pkg::HOST_WRITE_ADDRESS &&
     shift_ff != smbus_charger_pkg::HOST_READ_ADDRESS)
    |=> !o_sda_oe && state_ff == ST_IDLE;
  endproperty
  a_foreign_nack: assert property (p_foreign_nack) // see RQ3
    else $error("foreign address acknowledged");

  property p_bad_cmd;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_drop |=> !cmd_valid_ff && !o_sda_oe;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) // see RQ17
    else $error("bad command stored or acknowledged");

  property p_no_high;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    ##1 !o_sda_out;
  endproperty
  a_no_high: assert property (p_no_high) // see RQ14
    else $error("data line driven high");

  property p_stop_idle;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    stop_ev |=> state_ff == ST_IDLE && !o_sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) // see RQ19
    else $error("stop did not return to idle");

  property p_write_only_commit;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !$stable(o_charger_mode) || !$stable(o_charge_current)
    |-> $past(wr_commit);
  endproperty
  a_write_only_commit: assert property (p_write_only_commit) // see RQ16
    else $error("register changed without committed write");

  property p_release;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    release_done |=> !o_sda_oe ##1 !o_sda_oe;
  endproperty
  a_release: assert property (p_release) // see RQ10
    else $error("bus not released after timeout");

  property p_alert_cause;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_alert) |-> $past(alert_done) && $past(alert_pend_ff, 2);
  endproperty
  a_alert_cause: assert property (p_alert_cause) // see RQ11
    else $error("alert rose without aged status change");

  property p_fault_clear;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (status_rd && !chgoc_s) |=> !chgoc_lat_ff;
  endproperty
  a_fault_clear: assert property (p_fault_clear) // see RQ15
    else $error("fault latch not cleared by status read");

  property p_wdog_kick;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    wdog_svc |-> ##2 !o_watchdog_expired;
  endproperty
  a_wdog_kick: assert property (p_wdog_kick) // see RQ12
    else $error("watchdog expired right after service");

  c_write: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_commit);
  c_read: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    rd_done);
  c_nack: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_drop);
  c_alert: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_alert));

endmodule

// ==== smbus_host_model.sv ====
// Host model: drives the bus clock and data, reports each byte result
`timescale 1ns/1ps
module smbus_host_model #(
  parameter int HALF = 48 // Scaled bus rate
) (
  output logic       o_scl,
  output logic       o_sda_oe,
  input  wire logic  i_sda,
  output logic [7:0] o_result,
  output logic       o_result_valid
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_result = 8'h00;
    o_result_valid = 1'b0;
  end
  // Data moves only mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    #(HALF/2) o_sda_oe = ~b;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) r = i_sda;
    #(HALF/2);
  endtask
  task automatic start();
    o_scl = 1'b0;
    #(HALF/2) o_sda_oe = 1'b0;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) o_sda_oe = 1'b1;
    #(HALF/2);
  endtask
  task automatic stop();
    o_scl = 1'b0;
    #(HALF/2) o_sda_oe = 1'b1;
    #(HALF/2) o_scl = 1'b1;
    #(HALF/2) o_sda_oe = 1'b0;
    #HALF;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ak, input logic rd);
    logic [7:0] rx;
    logic       a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ak, a);
    o_result = rd ? rx : {7'h00, a};
    o_result_valid = 1'b1;
    #1 o_result_valid = 1'b0;
  endtask
  task automatic stall(input int ns);
    o_scl = 1'b0;
    #ns;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the charger slave port
`timescale 1ns/1ps
module tb_top;
  localparam int ALERT = 200;
  localparam int REL   = 400;
  localparam int DEG   = 50;
  localparam int WD    = 2000;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [15:0] flags = 16'h0000;
  logic        chgoc = 1'b0;
  logic        acoc = 1'b0;
  logic        kick = 1'b0;
  logic        scl, h_oe, d_oe, d_out, rv, alert, wexp, b;
  logic [7:0]  res;
  logic [15:0] regs [4];
  logic [15:0] wv [4];
  logic [7:0]  cmds [4] = '{8'h12, 8'h14, 8'h15, 8'h3f};
  logic [7:0]  bad [4] = '{8'h00, 8'h20, 8'h13, 8'h18};
  logic [7:0]  exp_q [$];
  logic [31:0] seed = 32'hf5af;
  int          n_errors = 0;
  int          check_count = 0;
  wire         sda = ~(h_oe | d_oe);
  always #2.5 i_core_clk = ~i_core_clk;
  smbus_charger_slave_port #(.ALERT_CYC(36'(ALERT)), .RELEASE_CYC(36'(REL)),
    .DEGLITCH_CYC(36'(DEG)), .WDOG_CYC(36'(WD))) i_smbus_charger_slave_port (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(d_out), .o_sda_oe(d_oe),
    .i_status_flags(flags), .i_chgoc_detect(chgoc), .i_acoc_detect(acoc),
    .i_watchdog_reset(kick), .o_alert(alert), .o_watchdog_expired(wexp),
    .o_charger_mode(regs[0]), .o_charge_current(regs[1]),
    .o_charge_voltage(regs[2]), .o_input_current(regs[3]));
  smbus_host_model i_smbus_host_model (.o_scl(scl), .o_sda_oe(h_oe),
    .i_sda(sda), .o_result(res), .o_result_valid(rv));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check_val(input logic [15:0] got, input logic [15:0] e);
    check_count++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic s();
    i_smbus_host_model.start();
  endtask
  task automatic p();
    i_smbus_host_model.stop();
  endtask
  task automatic put(input logic [7:0] v, input logic [7:0] e);
    exp_q.push_back(e);
    i_smbus_host_model.xfer(v, 1'b1, 1'b0);
  endtask
  task automatic get(input logic [7:0] e, input logic a);
    exp_q.push_back(e);
    i_smbus_host_model.xfer(8'hff, a, 1'b1);
  endtask
  // Word write, low byte first, no checksum byte
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    s();
    put(8'h12, 8'h00);
    put(c, 8'h00);
    put(d[7:0], 8'h00);
    put(d[15:8], 8'h00);
    p();
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    s();
    put(8'h12, 8'h00);
    put(c, 8'h00);
    s();
    put(8'h13, 8'h00);
    get(e[7:0], 1'b0);
    get(e[15:8], 1'b1);
    p();
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge rv) begin
    check_val({8'h00, res}, exp_q.size() ? {8'h00, exp_q.pop_front()} : 'x);
  end
  initial begin
    #500000;
    n_errors++;
    complete_run();
  end
  initial begin
    cyc(4);
    i_sys_rst <= 1'b0;
    cyc(10);
    seed = xs(seed);
    flags <= (seed[15:0] & 16'hfffc) | 16'h0100;
    cyc(ALERT - 10);
    check_val({15'h0, alert}, 16'h0000);
    cyc(30);
    check_val({15'h0, alert}, 16'h0001);
    $display("alert test done");
    wr(8'h13, 16'hffff);
    rd(8'h13, flags);
    chgoc <= 1'b1;
    acoc <= 1'b1;
    cyc(5);
    chgoc <= 1'b0;
    acoc <= 1'b0;
    cyc(5);
    rd(8'h13, flags | 16'h0003);
    rd(8'h13, flags);
    $display("status test done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wv[i] = seed[15:0];
      wr(cmds[i], wv[i]);
      cyc(5);
      check_val(regs[i], wv[i]);
      rd(cmds[i], wv[i]);
    end
    s();
    put(8'h12, 8'h00);
    put(8'h14, 8'h00);
    put(8'h5a, 8'h00);
    p();
    cyc(5);
    check_val(regs[1], wv[1]);
    $display("register test done");
    foreach (bad[j]) begin
      s();
      put(bad[j], 8'h01);
      p();
    end
    s();
    put(8'h12, 8'h00);
    put(8'h16, 8'h01);
    s();
    put(8'h13, 8'h01);
    p();
    $display("refusal test done");
    s();
    for (int k = 7; k >= 0; k--) i_smbus_host_model.bit_io(cmds[0][k], b);
    i_smbus_host_model.stall(60);
    @(negedge i_core_clk);
    check_val({14'h0, d_oe, d_out}, 16'h0002);
    i_smbus_host_model.stall(REL * 5 + 100);
    @(negedge i_core_clk);
    check_val({15'h0, d_oe}, 16'h0000);
    p();
    $display("release test done");
    cyc(WD + 20);
    check_val({15'h0, wexp}, 16'h0001);
    kick <= 1'b1;
    cyc(DEG - 20);
    kick <= 1'b0;
    cyc(10);
    check_val({15'h0, wexp}, 16'h0001);
    kick <= 1'b1;
    cyc(DEG + 10);
    kick <= 1'b0;
    cyc(5);
    check_val({15'h0, wexp}, 16'h0000);
    $display("watchdog test done");
    complete_run();
  end
endmodule
